// File: hw/tmv_engine.sv
// top: weight loader, two-stage ternary matrix-vector pipeline
`timescale 1ns/10ps
module tmv_engine (
    input wire logic clk,
    input wire logic resetn,
    input wire logic loadValid,
    input wire logic [tmv_pkg::WCODE_W-1:0] loadWeight,
    input wire logic vecValid,
    input wire logic [tmv_pkg::DATA_W-1:0] vecElem0,
    input wire logic [tmv_pkg::DATA_W-1:0] vecElem1,
    input wire logic [tmv_pkg::DATA_W-1:0] vecElem2,
    input wire logic [tmv_pkg::DATA_W-1:0] vecElem3,
    output logic loaded,
    output logic resValid,
    output logic [tmv_pkg::DATA_W-1:0] resCol0,
    output logic [tmv_pkg::DATA_W-1:0] resCol1
);
    import tmv_pkg::*;

    logic rstSync1_r;
    logic rstSync2_r;
    logic rstn;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rstSync1_r <= 1'b0;
            rstSync2_r <= 1'b0;
        end else begin
            rstSync1_r <= 1'b1;
            rstSync2_r <= rstSync1_r;
        end
    end
    assign rstn = rstSync2_r;

    // pin synchronisers, two stages each
    tmv_vec_t pinS1_r;
    tmv_vec_t pinS2_r;
    logic [WCODE_W:0] ldS1_r;
    logic [WCODE_W:0] ldS2_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pinS1_r <= '0;
            pinS2_r <= '0;
            ldS1_r <= '0;
            ldS2_r <= '0;
        end else begin
            pinS1_r <= {vecValid, vecElem3, vecElem2, vecElem1, vecElem0};
            pinS2_r <= pinS1_r;
            ldS1_r <= {loadValid, loadWeight};
            ldS2_r <= ldS1_r;
        end
    end

    tmv_mode_t mode_r;
    logic [IDX_W-1:0] loadIdx_r;
    logic [NWEIGHTS*WCODE_W-1:0] weights_r;
    logic ldValid;
    logic [WCODE_W-1:0] ldCode;

    assign ldValid = ldS2_r[WCODE_W];
    assign ldCode = ldS2_r[WCODE_W-1:0];

    // weight array filled in order, column 0 rows 0..3 then column 1
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            weights_r <= '0;
        end else if (mode_r == TMV_LOADING && ldValid) begin
            weights_r[loadIdx_r*WCODE_W +: WCODE_W] <= ldCode;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_r <= TMV_LOADING;
            loadIdx_r <= IDX_RESET;
        end else begin
            case (mode_r)
                TMV_LOADING: begin
                    if (ldValid) begin
                        loadIdx_r <= loadIdx_r + 3'h1;
                        if (loadIdx_r == IDX_W'(NWEIGHTS - 1)) begin
                            mode_r <= TMV_RUNNING;
                        end
                    end
                end
                TMV_RUNNING: begin
                    mode_r <= TMV_RUNNING;
                end
                default: begin
                    mode_r <= TMV_LOADING;
                end
            endcase
        end
    end

    // stage 1: column sums captured into the pipeline register
    logic signed [DATA_W-1:0] sum0;
    logic signed [DATA_W-1:0] sum1;
    tmv_res_t stage_r;

    tmv_column uCol0 (
        .vec(pinS2_r),
        .colWeights(weights_r[ROWS*WCODE_W-1:0]),
        .sum(sum0)
    );

    tmv_column uCol1 (
        .vec(pinS2_r),
        .colWeights(weights_r[NWEIGHTS*WCODE_W-1:ROWS*WCODE_W]),
        .sum(sum1)
    );

    // result valid gated until all weights are held; sums are captured regardless
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stage_r <= '0;
        end else begin
            stage_r.valid <= pinS2_r.valid && mode_r == TMV_RUNNING;
            stage_r.col0 <= sum0;
            stage_r.col1 <= sum1;
        end
    end

    // stage 2: outputs presented the cycle after capture
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            resValid <= 1'b0;
            resCol0 <= DATA_RESET;
            resCol1 <= DATA_RESET;
            loaded <= 1'b0;
        end else begin
            resValid <= stage_r.valid;
            resCol0 <= stage_r.col0;
            resCol1 <= stage_r.col1;
            loaded <= mode_r == TMV_RUNNING;
        end
    end
endmodule

// File: hw/tmv_pkg.sv
// package: constants and carrier types for the ternary matrix-vector engine
package tmv_pkg;
    localparam int ROWS = 4;
    localparam int COLS = 2;
    localparam int DATA_W = 8;
    localparam int WCODE_W = 2;
    localparam int NWEIGHTS = ROWS * COLS;
    localparam int IDX_W = 3;
    localparam int ACC_W = 10;
    localparam logic [WCODE_W-1:0] W_ZERO = 2'h0;
    localparam logic [WCODE_W-1:0] W_PLUS = 2'h1;
    localparam logic [WCODE_W-1:0] W_MINUS = 2'h3;
    localparam logic [IDX_W-1:0] IDX_RESET = 3'h0;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

    typedef enum logic [0:0] {
        TMV_LOADING = 1'b0,
        TMV_RUNNING = 1'b1
    } tmv_mode_t;

    typedef struct packed {
        logic valid;
        logic signed [DATA_W-1:0] elem3;
        logic signed [DATA_W-1:0] elem2;
        logic signed [DATA_W-1:0] elem1;
        logic signed [DATA_W-1:0] elem0;
    } tmv_vec_t;

    typedef struct packed {
        logic valid;
        logic signed [DATA_W-1:0] col1;
        logic signed [DATA_W-1:0] col0;
    } tmv_res_t;
endpackage

// File: hw/tmv_column.sv
// one column of ternary accumulation, combinational
`timescale 1ns/10ps
module tmv_column (
    input wire tmv_pkg::tmv_vec_t vec,
    input wire logic [tmv_pkg::ROWS*tmv_pkg::WCODE_W-1:0] colWeights,
    output logic signed [tmv_pkg::DATA_W-1:0] sum
);
    import tmv_pkg::*;

    function automatic logic signed [ACC_W-1:0] term(
        input logic [WCODE_W-1:0] w,
        input logic signed [DATA_W-1:0] x
    );
        logic signed [ACC_W-1:0] ext;
        ext = ACC_W'(x);
        case (w)
            W_PLUS: term = ext;
            W_MINUS: term = -ext;
            default: term = '0;
        endcase
    endfunction

    logic signed [ACC_W-1:0] acc;

    always_comb begin
        acc = term(colWeights[1:0], vec.elem0)
            + term(colWeights[3:2], vec.elem1)
            + term(colWeights[5:4], vec.elem2)
            + term(colWeights[7:6], vec.elem3);
        sum = acc[DATA_W-1:0]; // wraps to 8 bits
    end
endmodule

// File: verification/tmv_engine_assertions.sv
// port checker for the ternary matrix-vector engine
`timescale 1ns/10ps
module tmv_engine_assertions (
    input wire logic clk, resetn, loadValid, vecValid, loaded, resValid,
    input wire logic [7:0] vecElem0, vecElem1, vecElem2, vecElem3, resCol0, resCol1
);
    wire logic zeroIn = ~|{vecElem0, vecElem1, vecElem2, vecElem3};
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    chk_vector_answered: assert property (vecValid && loaded |-> ##[4:5] resValid)
        else $error("vector lost");
    chk_no_spurious: assert property (resValid |-> $past(vecValid, 4) || $past(vecValid, 5))
        else $error("result without vector");
    chk_weights_kept: assert property (loaded |=> loaded)
        else $error("loaded dropped");
    chk_unloaded_quiet: assert property (!loaded |-> !resValid)
        else $error("result before load");
    chk_load_time: assert property ($rose(loaded) |-> $past(loadValid, 4) || $past(loadValid, 5))
        else $error("loaded at wrong time");
    chk_zero_sum: assert property (resValid && $past(zeroIn, 4) && $past(zeroIn, 5)
        |-> resCol0 == 8'h00 && resCol1 == 8'h00)
        else $error("zero vector gave nonzero");
    cover property ($rose(loaded));
    cover property (resValid ##1 resValid ##1 resValid);
    cover property (resValid && resCol0 == 8'h7E);
endmodule
bind tmv_engine tmv_engine_assertions chk (.clk, .resetn, .loadValid, .vecValid, .loaded,
    .resValid, .vecElem0, .vecElem1, .vecElem2, .vecElem3, .resCol0, .resCol1);

// File: verification/tmv_mcu.sv
// microcontroller model driving the engine pins
`timescale 1ns/10ps
module tmv_mcu (
    input wire logic clk,
    output logic loadValid, vecValid,
    output logic [1:0] loadWeight,
    output logic [7:0] e0, e1, e2, e3
);
    initial {loadValid, vecValid, loadWeight, e0, e1, e2, e3} = '0;
    task automatic load(input logic [1:0] w);
        @(negedge clk) {loadValid, loadWeight} = {1'b1, w};
    endtask
    task automatic send(input logic [7:0] a, b, c, d);
        @(negedge clk) {vecValid, e0, e1, e2, e3} = {1'b1, a, b, c, d};
    endtask
    // released pins show garbage, not the last value
    task automatic idle;
        @(negedge clk) {loadValid, vecValid, loadWeight, e0, e1, e2, e3} =
            ~{2'b11, loadWeight, e0, e1, e2, e3};
    endtask
endmodule

// File: verification/tmv_engine_test.sv
// self-checking bench for the ternary matrix-vector engine
`timescale 1ns/10ps
`define CHK(a, b) begin testsRun++; if ((a) !== (b)) begin errors++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module tmv_engine_test;
    import tmv_pkg::*;
    logic clk = 0, resetn = 0, loadValid, vecValid, loaded, resValid;
    logic [1:0] loadWeight;
    logic [7:0] e0, e1, e2, e3, resCol0, resCol1;
    logic [1:0] w[8] = '{2'h1, 2'h3, 2'h0, 2'h1, 2'h2, 2'h1, 2'h3, 2'h1};
    logic [15:0] q[$];
    logic [15:0] expv;
    int errors = 0, testsRun = 0;
    initial forever #2.5 clk = ~clk;
    tmv_mcu mcu (.clk, .loadValid, .vecValid, .loadWeight, .e0, .e1, .e2, .e3);
    tmv_engine dut (.clk, .resetn, .loadValid, .loadWeight, .vecValid, .vecElem0(e0),
        .vecElem1(e1), .vecElem2(e2), .vecElem3(e3), .loaded, .resValid, .resCol0, .resCol1);
    function automatic logic [7:0] col(int c, logic [7:0] a, b, d, e);
        logic [7:0] x[4] = '{a, b, d, e};
        logic [7:0] s = 8'h00;
        for (int r = 0; r < 4; r++) begin
            if (w[c*4+r] == W_PLUS) s += x[r];
            if (w[c*4+r] == W_MINUS) s -= x[r];
        end
        return s;
    endfunction
    task automatic tsend(logic [7:0] a, b, d, e);
        mcu.send(a, b, d, e);
        if (loaded === 1'b1) q.push_back({col(1, a, b, d, e), col(0, a, b, d, e)});
    endtask
    always @(negedge clk) if (resValid !== 1'b0) begin
        expv = q.size() ? q.pop_front() : 'x;
        `CHK({resCol1, resCol0}, expv)
    end
    task automatic t_refuse;
        tsend(8'h05, 8'h05, 8'h05, 8'h05);
        mcu.idle;
        repeat (8) @(negedge clk);
        `CHK(loaded, 1'b0)
        $display("t_refuse done");
    endtask
    task automatic t_load;
        foreach (w[i]) mcu.load(w[i]);
        mcu.idle;
        repeat (6) @(negedge clk);
        `CHK(loaded, 1'b1)
        mcu.load(2'h3);
        mcu.idle;
        $display("t_load done");
    endtask
    task automatic t_stream;
        tsend(8'h02, 8'hFF, 8'h03, 8'h00);
        tsend(8'h7F, 8'h80, 8'h01, 8'h7F);
        repeat (3) tsend(8'h00, 8'h00, 8'h00, 8'h00);
        mcu.idle;
        repeat (8) @(negedge clk);
        `CHK(q.size(), 0)
        $display("t_stream done");
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", testsRun, errors);
        if (errors == 0 && testsRun > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge clk);
        resetn = 1;
        repeat (3) @(negedge clk);
        t_refuse;
        t_load;
        t_stream;
        complete_run;
    end
    initial begin
        #2000;
        errors++;
        complete_run;
    end
endmodule
